// [pkg/clhc_pkg.sv]
// Constants and carrier types for the cell link health and link group control block
package clhc_pkg;

  // Link organisation: block A holds links 0..3, block B links 4..7
  localparam int NUM_LINKS = 8;
  localparam int LINKS_PER_GROUP = 4;
  localparam int NUM_GROUPS = NUM_LINKS / LINKS_PER_GROUP;
  localparam int DATA_W = 32;

  // Transmit cell framing and buffering
  localparam int CELL_WORDS = 16;
  localparam int CELL_CNT_W = 4;
  localparam logic [CELL_CNT_W-1:0] CELL_LAST = CELL_CNT_W'(CELL_WORDS - 1);
  localparam int TX_FIFO_DEPTH = 16;

  // Receive sequence health counts
  localparam int RUN_W = 2;
  localparam int SEQ_RUN = 3;
  localparam int REMOVE_COUNT = 3;
  localparam int REJOIN_RUN = 3;
  localparam logic [RUN_W-1:0] SEQ_RUN_LAST = RUN_W'(SEQ_RUN - 1);
  localparam logic [RUN_W-1:0] REMOVE_LAST = RUN_W'(REMOVE_COUNT - 1);
  localparam logic [RUN_W-1:0] REJOIN_LAST = RUN_W'(REJOIN_RUN - 1);

  // Register map, byte-wide registers at their absolute addresses
  localparam int ADDR_W = 18;
  localparam logic [ADDR_W-1:0] STATUS_OFS [NUM_LINKS] = '{
    18'h30808, 18'h30818, 18'h30828, 18'h30838,
    18'h30908, 18'h30918, 18'h30928, 18'h30938
  };
  localparam logic [ADDR_W-1:0] GROUP_CTRL_OFS = 18'h30A03;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] GROUP_CTRL_RST = 8'h00;

  // Field positions; printed bit 0 is the MSb, so bit n sits at 7-n
  localparam int STAT_FRAMING_BIT = 2;
  localparam int STAT_UNDERFLOW_BIT = 1;
  localparam int STAT_OVERFLOW_BIT = 0;
  localparam int CTRL_HOLD_BIT = 7;
  localparam int CTRL_BUNDLE_BIT = 6;
  localparam int CTRL_REJOIN_A_BIT = 4;
  localparam int CTRL_REMOVE_A_BIT = 3;
  localparam int CTRL_REJOIN_B_BIT = 1;
  localparam int CTRL_REMOVE_B_BIT = 0;

  // One cell word on the transmit path
  typedef struct packed {
    logic sop;
    logic [DATA_W-1:0] data;
  } clhc_word_t;

  // Per-link sticky transmit flags, msb first matching status bits 2..0
  typedef struct packed {
    logic framing;
    logic underflow;
    logic overflow;
  } clhc_flags_t;

  // Register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } clhc_reg_req_t;

  // Whole state of the top module
  typedef struct packed {
    clhc_flags_t [NUM_LINKS-1:0] flags;
    logic [NUM_LINKS-1:0][CELL_CNT_W-1:0] cell_cnt;
    logic [NUM_LINKS-1:0][RUN_W-1:0] err_run;
    logic [NUM_LINKS-1:0][RUN_W-1:0] ok_run;
    logic [NUM_LINKS-1:0][RUN_W-1:0] excess_cnt;
    logic [NUM_LINKS-1:0] rx_good;
    logic [NUM_LINKS-1:0] excess_evt;
    logic [NUM_LINKS-1:0] tx_valid;
    clhc_word_t [NUM_LINKS-1:0] tx_word;
    logic [NUM_LINKS-1:0] rx_valid;
    logic [NUM_LINKS-1:0][DATA_W-1:0] rx_data;
    logic [7:0] ctrl;
    logic [7:0] rdata;
  } clhc_state_t;

endpackage

// [verilog/clhc_fifo.sv]
// Synchronous valid/ready FIFO used as the per-link transmit cell buffer
`timescale 1ns/100ps
module clhc_fifo
  import clhc_pkg::*;
#(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } clhc_fifo_state_t;

  clhc_fifo_state_t s_q;
  clhc_fifo_state_t s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Honest full and empty taken straight from the count
  assign in_ready = (s_q.count != CNT_FULL);
  assign out_valid = (s_q.count != '0);
  assign out_data = mem[s_q.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer wrap works for any depth, not only powers of two
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr_ptr = (s_q.wr_ptr == PTR_LAST) ? '0 : s_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_d.rd_ptr = (s_q.rd_ptr == PTR_LAST) ? '0 : s_q.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10: s_d.count = s_q.count + 1'b1;
      2'b01: s_d.count = s_q.count - 1'b1;
      default: s_d.count = s_q.count;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage needs no reset; nothing reads a slot before it is written
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[s_q.wr_ptr] <= in_data;
    end
  end

endmodule

// [verilog/clhc_top.sv]
// Cell link health monitor, transmit buffering and link group control
//
// Behaviour
// - A popped word that should open a cell but lacks its start marker sets the framing flag.
// - The line asking for a word mid-cell while the transmit buffer is empty sets underrun.
// - The fabric offering a word while the transmit buffer is full sets overrun.
// - Ready to the fabric drops when the buffer is full, and the fabric must then hold off.
// - Alarm rises for a link while any set flag has its enable set, and never otherwise.
// - With hold-transmit set a link sends nothing while its receive side is not good.
// - With bundling set every good link in a group passes cells regardless of the others.
// - With bundling clear a group passes cells only while all of its links are good.
// - With rejoin set for its block a bad link turns good after three clean cells in a row.
// - With removal set for its block a link turns bad after three excessive error events.
// - Three consecutive received cells with sequence errors make one excessive error event.
`timescale 1ns/100ps
module clhc_top
  import clhc_pkg::*;
#(
  parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire clhc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire clhc_flags_t [NUM_LINKS-1:0] alarm_enable,
  output logic [NUM_LINKS-1:0] alarm,
  input wire logic [NUM_LINKS-1:0] fab_tx_valid,
  output logic [NUM_LINKS-1:0] fab_tx_ready,
  input wire clhc_word_t [NUM_LINKS-1:0] fab_tx_word,
  input wire logic [NUM_LINKS-1:0] line_tx_req,
  output logic [NUM_LINKS-1:0] line_tx_valid,
  output clhc_word_t [NUM_LINKS-1:0] line_tx_word,
  input wire logic [NUM_LINKS-1:0] line_rx_valid,
  input wire logic [NUM_LINKS-1:0] line_rx_seq_err,
  input wire logic [NUM_LINKS-1:0][DATA_W-1:0] line_rx_data,
  output logic [NUM_LINKS-1:0] fab_rx_valid,
  output logic [NUM_LINKS-1:0][DATA_W-1:0] fab_rx_data,
  output logic [NUM_LINKS-1:0] rx_link_good,
  output logic [NUM_LINKS-1:0] excess_sequence_fault
);

  clhc_state_t s_q;
  clhc_state_t s_d;

  // Buffer drain side, one set per link
  logic [NUM_LINKS-1:0] buf_valid;
  logic [NUM_LINKS-1:0] buf_pop;
  clhc_word_t [NUM_LINKS-1:0] buf_word;

  // Combinational helpers derived from registered state and from the register port address
  logic [NUM_LINKS-1:0] tx_hold;
  logic [NUM_GROUPS-1:0] group_all_good;
  logic [NUM_LINKS-1:0] rejoin_en;
  logic [NUM_LINKS-1:0] remove_en;
  logic [NUM_LINKS-1:0] status_hit;
  logic ctrl_hit;

  // One transmit buffer per link; its ready is the backpressure to the fabric
  for (genvar g = 0; g < NUM_LINKS; g++) begin : g_txbuf
    clhc_fifo #(
      .WIDTH($bits(clhc_word_t)),
      .DEPTH(FIFO_DEPTH)
    ) u_txbuf (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(fab_tx_valid[g]),
      .in_ready(fab_tx_ready[g]),
      .in_data(fab_tx_word[g]),
      .out_valid(buf_valid[g]),
      .out_ready(buf_pop[g]),
      .out_data(buf_word[g])
    );
  end

  // Per-link control selection and group health
  always_comb begin
    for (int i = 0; i < NUM_LINKS; i++) begin
      // Gating reacts at once, so a cell in flight may be cut short
      tx_hold[i] = s_q.ctrl[CTRL_HOLD_BIT] && !s_q.rx_good[i];
      if (i < LINKS_PER_GROUP) begin
        rejoin_en[i] = s_q.ctrl[CTRL_REJOIN_A_BIT];
        remove_en[i] = s_q.ctrl[CTRL_REMOVE_A_BIT];
      end else begin
        rejoin_en[i] = s_q.ctrl[CTRL_REJOIN_B_BIT];
        remove_en[i] = s_q.ctrl[CTRL_REMOVE_B_BIT];
      end
      buf_pop[i] = line_tx_req[i] && !tx_hold[i];
    end
    for (int g = 0; g < NUM_GROUPS; g++) begin
      group_all_good[g] = &s_q.rx_good[g*LINKS_PER_GROUP +: LINKS_PER_GROUP];
    end
  end

  // Address decode of the register port
  always_comb begin
    ctrl_hit = (reg_req.addr == GROUP_CTRL_OFS);
    for (int i = 0; i < NUM_LINKS; i++) begin
      status_hit[i] = (reg_req.addr == STATUS_OFS[i]);
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.excess_evt = '0;

    // Register writes; only the control byte is writable
    if (reg_req.wr && ctrl_hit) begin
      s_d.ctrl = reg_req.wdata;
    end

    // Register reads land one cycle later; unmapped reads return zero
    if (reg_req.rd) begin
      s_d.rdata = 8'h00;
      if (ctrl_hit) begin
        s_d.rdata = s_q.ctrl;
      end
      for (int i = 0; i < NUM_LINKS; i++) begin
        if (status_hit[i]) begin
          s_d.rdata = STATUS_RST | {5'h00, s_q.flags[i]};
          // Reading a status byte clears it; new events below still win
          s_d.flags[i] = '0;
        end
      end
    end

    for (int i = 0; i < NUM_LINKS; i++) begin
      // Transmit frame processor
      s_d.tx_valid[i] = 1'b0;
      if (buf_pop[i] && buf_valid[i]) begin
        if ((s_q.cell_cnt[i] == '0) && !buf_word[i].sop) begin
          // Stray word dropped; framing resyncs on the next marker
          s_d.flags[i].framing = 1'b1;
        end else begin
          s_d.tx_valid[i] = 1'b1;
          s_d.tx_word[i] = buf_word[i];
          s_d.cell_cnt[i] = (s_q.cell_cnt[i] == CELL_LAST) ? '0 : s_q.cell_cnt[i] + 1'b1;
        end
      end
      // Line wants a word inside a cell and nothing is buffered
      if (buf_pop[i] && !buf_valid[i] && (s_q.cell_cnt[i] != '0)) begin
        s_d.flags[i].underflow = 1'b1;
      end
      // Fabric ignored backpressure and the word is lost
      if (fab_tx_valid[i] && !fab_tx_ready[i]) begin
        s_d.flags[i].overflow = 1'b1;
      end

      // Receive sequence health
      if (line_rx_valid[i]) begin
        if (line_rx_seq_err[i]) begin
          s_d.ok_run[i] = '0;
          if (s_q.err_run[i] == SEQ_RUN_LAST) begin
            s_d.err_run[i] = '0;
            s_d.excess_evt[i] = 1'b1;
            if (remove_en[i] && s_q.rx_good[i]) begin
              if (s_q.excess_cnt[i] == REMOVE_LAST) begin
                s_d.excess_cnt[i] = '0;
                s_d.rx_good[i] = 1'b0;
              end else begin
                s_d.excess_cnt[i] = s_q.excess_cnt[i] + 1'b1;
              end
            end
          end else begin
            s_d.err_run[i] = s_q.err_run[i] + 1'b1;
          end
        end else begin
          s_d.err_run[i] = '0;
          if (!s_q.rx_good[i] && rejoin_en[i]) begin
            if (s_q.ok_run[i] == REJOIN_LAST) begin
              s_d.ok_run[i] = '0;
              s_d.excess_cnt[i] = '0;
              s_d.rx_good[i] = 1'b1;
            end else begin
              s_d.ok_run[i] = s_q.ok_run[i] + 1'b1;
            end
          end else begin
            s_d.ok_run[i] = '0;
          end
        end
      end

      // Cells go to the fabric by link health and bundling mode
      s_d.rx_valid[i] = line_rx_valid[i] && s_q.rx_good[i] &&
                        (s_q.ctrl[CTRL_BUNDLE_BIT] ||
                         group_all_good[i / LINKS_PER_GROUP]);
      if (line_rx_valid[i]) begin
        s_d.rx_data[i] = line_rx_data[i];
      end
    end
  end

  // Single state register; links start good so traffic flows after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.rx_good <= '1;
      s_q.ctrl <= GROUP_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Alarm is a level that follows flags and enables together
  always_comb begin
    for (int i = 0; i < NUM_LINKS; i++) begin
      alarm[i] = |(s_q.flags[i] & alarm_enable[i]);
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = s_q.rdata;
  assign line_tx_valid = s_q.tx_valid;
  assign line_tx_word = s_q.tx_word;
  assign fab_rx_valid = s_q.rx_valid;
  assign fab_rx_data = s_q.rx_data;
  assign rx_link_good = s_q.rx_good;
  assign excess_sequence_fault = s_q.excess_evt;

endmodule

// [tb/clhc_top_properties.sv]
// Port-level temporal checks for the link health block
`timescale 1ns/100ps
module clhc_top_properties
  import clhc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire clhc_flags_t [NUM_LINKS-1:0] alarm_enable,
  input wire logic [NUM_LINKS-1:0] alarm,
  input wire logic [NUM_LINKS-1:0] fab_tx_valid,
  input wire logic [NUM_LINKS-1:0] fab_tx_ready,
  input wire logic [NUM_LINKS-1:0] line_rx_valid,
  input wire logic [NUM_LINKS-1:0] line_rx_seq_err,
  input wire logic [NUM_LINKS-1:0][DATA_W-1:0] line_rx_data,
  input wire logic [NUM_LINKS-1:0] fab_rx_valid,
  input wire logic [NUM_LINKS-1:0][DATA_W-1:0] fab_rx_data,
  input wire logic [NUM_LINKS-1:0] rx_link_good,
  input wire logic [NUM_LINKS-1:0] excess_sequence_fault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Link 0 carries the error cells in the bench; links 1 and 4 only see clean cells
  wire e0 = line_rx_valid[0] && line_rx_seq_err[0];
  wire c0 = line_rx_valid[0] && !line_rx_seq_err[0];
  // Error cells in the current run; idle cycles between cells leave it alone
  logic [1:0] err_run0;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_run0 <= 2'h0;
    end else if (c0) begin
      err_run0 <= 2'h0;
    end else if (e0) begin
      err_run0 <= (err_run0 == 2'h2) ? 2'h0 : err_run0 + 2'h1;
    end
  end
  property p_alarm;
    (!alarm[0] || |alarm_enable[0]) && (!alarm[1] || |alarm_enable[1]);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without enable");
  property p_ready;
    $fell(fab_tx_ready[1]) |-> $past(fab_tx_valid[1]);
  endproperty
  a_ready: assert property (p_ready) else $error("ready fell without push");
  property p_excess;
    excess_sequence_fault[0] |-> $past(e0) && ($past(err_run0) == 2'h2);
  endproperty
  a_excess: assert property (p_excess) else $error("excess without three errors");
  property p_gap;
    excess_sequence_fault[0] |=> !excess_sequence_fault[0] [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("excess run not restarted");
  property p_gate;
    fab_rx_valid[0] |-> $past(line_rx_valid[0] && rx_link_good[0]);
  endproperty
  a_gate: assert property (p_gate) else $error("cell passed on bad link");
  property p_data;
    fab_rx_valid[0] |-> fab_rx_data[0] == $past(line_rx_data[0]);
  endproperty
  a_data: assert property (p_data) else $error("cell data changed");
  property p_fell;
    $fell(rx_link_good[0]) |-> $past(e0) || $past(e0, 2);
  endproperty
  a_fell: assert property (p_fell) else $error("link removed without errors");
  property p_rose;
    $rose(rx_link_good[0]) |-> $past(c0) || $past(c0, 2);
  endproperty
  a_rose: assert property (p_rose) else $error("link rejoined without clean cell");
  cover property (excess_sequence_fault[0]);
  cover property ($fell(rx_link_good[0]));
  cover property (!fab_tx_ready[1]);
endmodule
bind clhc_top clhc_top_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .alarm_enable(alarm_enable), .alarm(alarm), .fab_tx_valid(fab_tx_valid),
  .fab_tx_ready(fab_tx_ready), .line_rx_valid(line_rx_valid),
  .line_rx_seq_err(line_rx_seq_err), .line_rx_data(line_rx_data),
  .fab_rx_valid(fab_rx_valid), .fab_rx_data(fab_rx_data), .rx_link_good(rx_link_good),
  .excess_sequence_fault(excess_sequence_fault));

// [tb/clhc_fabric_model.sv]
// Fabric-side cell source for one transmit link
`timescale 1ns/100ps
module clhc_fabric_model
  import clhc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic ready,
  output logic valid,
  output clhc_word_t word
);
  initial begin
    valid = 1'b0;
    word = '0;
  end
  // Idle word is inverted so stale data never looks current
  task automatic send(input int n, input logic sop_first);
    for (int k = 0; k < n; k++) begin
      while (!ready) begin
        valid = 1'b0;
        word = ~word;
        @(posedge ref_clk);
        #1;
      end
      valid = 1'b1;
      word.sop = sop_first && (k == 0);
      word.data = DATA_W'(k);
      @(posedge ref_clk);
      #1;
    end
    valid = 1'b0;
    word = ~word;
  endtask
endmodule

// [tb/clhc_top_tb_top.sv]
// Self-checking bench for the link health block
`timescale 1ns/100ps
module clhc_top_tb_top import clhc_pkg::*; ;
  localparam logic [7:0] FRM = 8'h01 << STAT_FRAMING_BIT;
  localparam logic [7:0] UFL = 8'h01 << STAT_UNDERFLOW_BIT;
  localparam logic [7:0] OFL = 8'h01 << STAT_OVERFLOW_BIT;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  clhc_reg_req_t reg_req = '0;
  clhc_flags_t [NUM_LINKS-1:0] alarm_enable = '0;
  logic [NUM_LINKS-1:0] alarm, fab_tx_ready, line_tx_valid, fab_rx_valid, rx_link_good, exc;
  logic [NUM_LINKS-1:0] tb_v = '0, line_tx_req = '0, line_rx_valid = '0, line_rx_seq_err = '0;
  logic m_v;
  logic [7:0] reg_rdata;
  clhc_word_t m_w;
  clhc_word_t [NUM_LINKS-1:0] tb_w = '0, line_tx_word;
  logic [NUM_LINKS-1:0][DATA_W-1:0] line_rx_data = '0, fab_rx_data;
  wire logic [NUM_LINKS-1:0] fab_tx_valid = {tb_v[7:1], m_v};
  wire clhc_word_t [NUM_LINKS-1:0] fab_tx_word = {tb_w[7:1], m_w};
  int err_count = 0, num_checks = 0, tx_n = 0, exc_n = 0, rx_n = 0;
  initial forever #5 ref_clk = ~ref_clk;
  // Small buffer so backpressure is reached in a few words
  clhc_top #(.FIFO_DEPTH(4)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .alarm_enable(alarm_enable), .alarm(alarm),
    .fab_tx_valid(fab_tx_valid), .fab_tx_ready(fab_tx_ready), .fab_tx_word(fab_tx_word),
    .line_tx_req(line_tx_req), .line_tx_valid(line_tx_valid), .line_tx_word(line_tx_word),
    .line_rx_valid(line_rx_valid), .line_rx_seq_err(line_rx_seq_err),
    .line_rx_data(line_rx_data), .fab_rx_valid(fab_rx_valid), .fab_rx_data(fab_rx_data),
    .rx_link_good(rx_link_good), .excess_sequence_fault(exc));
  clhc_fabric_model u_fab (.ref_clk(ref_clk), .ready(fab_tx_ready[0]), .valid(m_v), .word(m_w));
  // Sent words and excess events on link 0
  always @(posedge ref_clk) begin
    tx_n <= tx_n + int'(line_tx_valid[0]);
    exc_n <= exc_n + int'(exc[0]);
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One register access; for a read d is the expected byte
  task automatic reg_op(input logic r, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    reg_req = '{rd: r, wr: !r, addr: a, wdata: d};
    tick();
    reg_req = '0;
    if (r) chk("reg_rdata", 32'(reg_rdata), 32'(d));
    tick();
  endtask
  task automatic rx(input int l, input logic e, input logic exp);
    rx_n++;
    line_rx_valid = NUM_LINKS'(1) << l;
    line_rx_seq_err = {NUM_LINKS{e}};
    line_rx_data[l] = DATA_W'(rx_n);
    tick();
    chk("fab_rx_valid", 32'(fab_rx_valid[l]), 32'(exp));
  endtask
  task automatic quiet();
    line_rx_valid = '0;
    line_rx_data = ~line_rx_data;
    tick(2);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    close_out();
  end
  initial begin
    tick(5);
    rst_n = 1'b1;
    alarm_enable[0] = 3'b100;
    line_tx_req[0] = 1'b1;
    for (int i = 0; i < NUM_LINKS; i++) reg_op(1, STATUS_OFS[i], STATUS_RST);
    reg_op(1, GROUP_CTRL_OFS, GROUP_CTRL_RST);
    reg_op(0, GROUP_CTRL_OFS, 8'h24);
    reg_op(1, GROUP_CTRL_OFS, 8'h24);
    reg_op(0, STATUS_OFS[0], 8'hFF);
    reg_op(1, STATUS_OFS[0], 8'h00);
    reg_op(1, 18'h30A00, 8'h00);
    u_fab.send(16, 1'b1);
    tick(4);
    chk("tx count", 32'(tx_n), 32'd16);
    chk("last word", line_tx_word[0].data, 32'h0000000F);
    reg_op(1, STATUS_OFS[0], 8'h00);
    u_fab.send(5, 1'b1);
    tick(4);
    chk("alarm", 32'(alarm[0]), 32'd0);
    reg_op(1, STATUS_OFS[0], UFL);
    u_fab.send(11, 1'b0);
    tick(4);
    reg_op(1, STATUS_OFS[0], UFL);
    u_fab.send(1, 1'b0);
    tick(4);
    chk("alarm", 32'(alarm[0]), 32'd1);
    chk("tx count", 32'(tx_n), 32'd32);
    reg_op(1, STATUS_OFS[0], FRM);
    chk("alarm", 32'(alarm[0]), 32'd0);
    // Link 1 offers past backpressure on purpose
    tb_w[1].sop = 1'b1;
    tb_v[1] = 1'b1;
    tick();
    tb_w[1].sop = 1'b0;
    tick(3);
    chk("ready", 32'(fab_tx_ready[1]), 32'd0);
    tick();
    tb_v[1] = 1'b0;
    tick();
    reg_op(1, STATUS_OFS[1], OFL);
    reg_op(0, GROUP_CTRL_OFS, 8'h48);
    repeat (9) rx(0, 1'b1, 1'b1);
    quiet();
    chk("excess events", 32'(exc_n), 32'd3);
    chk("link good", 32'(rx_link_good[0]), 32'd0);
    rx(0, 1'b0, 1'b0);
    rx(1, 1'b0, 1'b1);
    quiet();
    reg_op(0, GROUP_CTRL_OFS, 8'h08);
    rx(1, 1'b0, 1'b0);
    rx(4, 1'b0, 1'b1);
    quiet();
    reg_op(0, GROUP_CTRL_OFS, 8'h80);
    u_fab.send(4, 1'b1);
    tick(8);
    chk("tx count", 32'(tx_n), 32'd32);
    reg_op(0, GROUP_CTRL_OFS, 8'h00);
    tick(8);
    chk("tx count", 32'(tx_n), 32'd36);
    reg_op(0, GROUP_CTRL_OFS, 8'h10);
    rx(0, 1'b1, 1'b0);
    repeat (3) rx(0, 1'b0, 1'b0);
    quiet();
    chk("link good", 32'(rx_link_good[0]), 32'd1);
    close_out();
  end
endmodule
